// *** bench/usr4_shift_reg_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "usr4_params.svh"
module usr4_shift_reg_sva #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clk_in, srst_in, clear_n_in, shift_clk_in, mode_sel_hi_in, mode_sel_lo_in,
   input wire logic par_in0_in, par_in1_in, par_in2_in, par_in3_in,
   input wire logic serial_in_right_in, serial_in_left_in,
   input wire logic out0_out, out1_out, out2_out, out3_out,
   input wire logic word_valid_out, word_ready_in,
   input wire logic [`USR4_STAGES-1:0] word_data_out,
   input wire logic edge_dropped_out
);
   logic prev;
   logic tk;
   logic [3:0] q;
   logic [3:0] p;
   logic [1:0] m;
   always_ff @(posedge clk_in) prev <= srst_in ? 1'b0 : shift_clk_in;
   assign tk = clear_n_in && shift_clk_in && !prev;
   assign q = {out3_out, out2_out, out1_out, out0_out};
   assign p = {par_in3_in, par_in2_in, par_in1_in, par_in0_in};
   assign m = {mode_sel_hi_in, mode_sel_lo_in};
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   clear_low_a: assert property (!clear_n_in |-> q == 4'h0)
      else $error("outputs not low");
   par_load_a: assert property (tk && m == 2'h3 |=> edge_dropped_out || !clear_n_in
      || q == $past(p)) else $error("load wrong");
   right_shift_a: assert property (tk && m == 2'h1 |=> edge_dropped_out || !clear_n_in
      || q == {$past(q[2:0]), $past(serial_in_right_in)}) else $error("right shift wrong");
   left_shift_a: assert property (tk && m == 2'h2 |=> edge_dropped_out || !clear_n_in
      || q == {$past(serial_in_left_in), $past(q[3:1])}) else $error("left shift wrong");
   hold_mode_a: assert property (tk && m == 2'h0 |=> !clear_n_in || $stable(q))
      else $error("hold changed");
   idle_clock_a: assert property (clear_n_in && !tk |=> !clear_n_in || $stable(q))
      else $error("change without rise");
   drop_keep_a: assert property (edge_dropped_out && clear_n_in |-> $stable(q)
      && $past(word_valid_out)) else $error("refused edge moved");
   word_hold_a: assert property (word_valid_out && !word_ready_in |=> word_valid_out
      && $stable(word_data_out)) else $error("word lost");
endmodule : usr4_shift_reg_sva
bind usr4_shift_reg usr4_shift_reg_sva #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.clk_in(clk_in),
   .srst_in(srst_in), .clear_n_in(clear_n_in), .shift_clk_in(shift_clk_in),
   .mode_sel_hi_in(mode_sel_hi_in), .mode_sel_lo_in(mode_sel_lo_in), .par_in0_in(par_in0_in),
   .par_in1_in(par_in1_in), .par_in2_in(par_in2_in), .par_in3_in(par_in3_in),
   .serial_in_right_in(serial_in_right_in), .serial_in_left_in(serial_in_left_in),
   .out0_out(out0_out), .out1_out(out1_out), .out2_out(out2_out), .out3_out(out3_out),
   .word_valid_out(word_valid_out), .word_ready_in(word_ready_in),
   .word_data_out(word_data_out), .edge_dropped_out(edge_dropped_out));
`default_nettype wire

// *** bench/usr4_shift_reg_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("unexpected %0t got %h want %h", $time, a, b); end end
module usr4_shift_reg_tb;
   logic clk_in = 0, srst_in = 1, clear_n = 1, sclk = 0, hi = 0, lo = 0, sr = 0, sl = 0;
   logic stall = 0, valid, ready, drop;
   logic [3:0] p = 4'h0, e = 4'h0, q, wd, w;
   logic [31:0] r;
   logic [3:0] eq[$];
   int num_errors = 0, total_checks = 0, seed = 77409, cyc = 0;
   always #50 clk_in = ~clk_in;
   usr4_shift_reg dut (.clk_in(clk_in), .srst_in(srst_in), .clear_n_in(clear_n),
      .shift_clk_in(sclk), .mode_sel_hi_in(hi), .mode_sel_lo_in(lo), .par_in0_in(p[0]),
      .par_in1_in(p[1]), .par_in2_in(p[2]), .par_in3_in(p[3]), .serial_in_right_in(sr),
      .serial_in_left_in(sl), .out0_out(q[0]), .out1_out(q[1]), .out2_out(q[2]),
      .out3_out(q[3]), .word_valid_out(valid), .word_ready_in(ready), .word_data_out(wd),
      .edge_dropped_out(drop));
   usr4_sink sink (.clk_in(clk_in), .srst_in(srst_in), .stall_in(stall), .ready_out(ready));
   task automatic summarize;
      if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   always @(posedge clk_in)
   begin
      cyc++;
      if (valid === 1'b1 && ready === 1'b1)
      begin
         w = (eq.size() != 0) ? eq.pop_front() : 4'hx;
         `CHK(wd, w)
      end
      if (cyc == 6000)
      begin
         num_errors++;
         summarize();
      end
   end
   task automatic step(input logic [1:0] m, input logic [3:0] d, input logic a, b, dr);
      @(negedge clk_in);
      {hi, lo} = m;
      p = d;
      sr = a;
      sl = b;
      sclk = 1;
      @(negedge clk_in);
      sclk = 0;
      if (!dr && m == 2'h3) e = d;
      if (!dr && m == 2'h1) e = {e[2:0], a};
      if (!dr && m == 2'h2) e = {b, e[3:1]};
      if (!dr && m != 2'h0) eq.push_back(e);
      `CHK(drop, dr)
      `CHK(q, e)
   endtask : step
   task automatic drain;
      stall = 0;
      for (int i = 0; i < 100 && eq.size() != 0; i++) @(negedge clk_in);
      `CHK(eq.size(), 0)
      `CHK(valid, 1'b0)
   endtask : drain
   initial
   begin
      repeat (16) @(negedge clk_in);
      srst_in = 0;
      `CHK(q, 4'h0)
      for (int i = 0; i < 64; i++)
      begin
         r = $random(seed);
         step(i[1:0], r[3:0], r[4], r[5], 1'b0);
      end
      for (int i = 0; i < 8; i++)
      begin
         @(negedge clk_in);
         r = $random(seed);
         {hi, lo, p, sr, sl} = r[7:0];
         #1 `CHK(q, e)
      end
      step(2'h3, 4'ha, 1'b0, 1'b0, 1'b0);
      @(negedge clk_in);
      clear_n = 0;
      e = 4'h0;
      #1 `CHK(q, 4'h0)
      @(negedge clk_in);
      clear_n = 1;
      #1 `CHK(q, 4'h0)
      drain();
      stall = 1;
      for (int i = 0; i < 16; i++) step(2'h2, 4'h0, 1'b0, i[0], 1'b0);
      step(2'h1, 4'h0, 1'b1, 1'b0, 1'b1);
      drain();
      summarize();
   end
endmodule : usr4_shift_reg_tb
`default_nettype wire

// *** bench/usr4_sink.sv ***
`timescale 1ns/1ps
`default_nettype none
module usr4_sink (
   // clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // stall request
   input wire logic stall_in,
   // drain side
   output logic ready_out
);
   int seed = 77409;
   // random ready, off while stalled
   always_ff @(posedge clk_in) ready_out <= !srst_in && !stall_in && ($random(seed) % 4 != 0);
endmodule : usr4_sink
`default_nettype wire

// *** rtl/usr4_params.svh ***
`ifndef USR4_PARAMS_SVH
`define USR4_PARAMS_SVH

// -----------------------------------------------------------------
// sizes
// -----------------------------------------------------------------
`define USR4_STAGES 4
`define USR4_FIFO_DEPTH 16

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define USR4_STAGE_RESET 4'h0
`define USR4_EDGE_RESET 1'b0

// -----------------------------------------------------------------
// mode select field positions
// -----------------------------------------------------------------
`define USR4_MODE_HI_POS 1
`define USR4_MODE_LO_POS 0

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define USR4_CLK_PERIOD_NS 100

`endif

// *** rtl/usr4_pkg.sv ***
package usr4_pkg;

   // -----------------------------------------------------------------
   // operating modes
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      USR4_HOLD,
      USR4_SHIFT_RIGHT,
      USR4_SHIFT_LEFT,
      USR4_LOAD
   } usr4_mode_t;

endpackage : usr4_pkg

// *** rtl/usr4_shift_reg.sv ***
// Overview of operation
// (RL1) Four stages each drive their own output and data can move through them either way.
// (RL2) A low on the clear input empties every stage and forces every output low at once.
// (RL3) With both mode selects high each rising shift clock edge loads the four parallel inputs; here an edge is refused while the word stream is full.
// (RL4) With mode_sel_lo high only, each rising edge moves every stage one place toward out3; here an edge is refused while the word stream is full.
// (RL5) In right shift serial_in_right enters out0, and it is ignored in every other mode.
// (RL6) With mode_sel_hi high only, each rising edge moves every stage one place toward out0; here an edge is refused while the word stream is full.
// (RL7) In left shift serial_in_left enters out3, and it is ignored in every other mode.
// (RL8) With both mode selects low the stages keep their values across edges.
// (RL9) With the shift clock resting low or high the outputs never change.
// (RL10) Every new stage value comes from the values held just before the edge, all at once.
// (RL11) State is kept with no shift clock activity and any clocking rate down to zero works.
// (RL12) The driving logic keeps mode and used data steady around each edge and frees clear before it.
`include "usr4_params.svh"
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------
// word fifo
// -----------------------------------------------------------------
module usr4_fifo #(
   parameter int WIDTH = `USR4_STAGES,
   parameter int DEPTH = `USR4_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("fifo depth must be a power of two of at least two");
   end
   if (WIDTH < 1)
   begin : g_bad_width
      $error("fifo width must be at least one");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] next_wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW-1:0] next_rd_ptr;
   logic [AW:0] count;
   logic [AW:0] next_count;
   logic push;
   logic pop;

   assign in_ready_out = (count != DEPTH[AW:0]);
   assign out_valid_out = (count != '0);
   assign out_data_out = mem[rd_ptr];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   always_comb
   begin
      next_mem = mem;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (push)
      begin
         next_mem[wr_ptr] = in_data_in;
         next_wr_ptr = wr_ptr + 1'b1;
      end
      if (pop)
      begin
         next_rd_ptr = rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
         next_count = count + 1'b1;
      end
      else if (pop && !push)
      begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem[i] <= '0;
         end
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         mem <= next_mem;
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end
endmodule : usr4_fifo

// -----------------------------------------------------------------
// universal shift register
// -----------------------------------------------------------------
module usr4_shift_reg #(
   parameter int FIFO_DEPTH = `USR4_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // device pins
   input wire logic clear_n_in,
   input wire logic shift_clk_in,
   input wire logic mode_sel_hi_in,
   input wire logic mode_sel_lo_in,
   input wire logic par_in0_in,
   input wire logic par_in1_in,
   input wire logic par_in2_in,
   input wire logic par_in3_in,
   input wire logic serial_in_right_in,
   input wire logic serial_in_left_in,
   // stage outputs
   output logic out0_out,
   output logic out1_out,
   output logic out2_out,
   output logic out3_out,
   // stream of stage words
   output logic word_valid_out,
   input wire logic word_ready_in,
   output logic [`USR4_STAGES-1:0] word_data_out,
   // edge refused while stream full
   output logic edge_dropped_out
);
   localparam int N = `USR4_STAGES;

   if (FIFO_DEPTH < 2)
   begin : g_bad_fifo_depth
      $error("fifo depth must be at least two");
   end

   // -----------------------------------------------------------------
   // mode decode
   // -----------------------------------------------------------------
   function automatic usr4_pkg::usr4_mode_t usr4_decode(input logic [1:0] sel);
      usr4_pkg::usr4_mode_t m;
      m = usr4_pkg::USR4_HOLD;
      unique case ({sel[`USR4_MODE_HI_POS], sel[`USR4_MODE_LO_POS]})
         2'h3: m = usr4_pkg::USR4_LOAD;
         2'h1: m = usr4_pkg::USR4_SHIFT_RIGHT;
         2'h2: m = usr4_pkg::USR4_SHIFT_LEFT;
         2'h0: m = usr4_pkg::USR4_HOLD;
      endcase
      return m;
   endfunction : usr4_decode

   logic [N-1:0] stage;
   logic [N-1:0] next_stage;
   logic clk_prev;
   logic next_clk_prev;
   logic dropped;
   logic next_dropped;
   logic rise;
   logic step;
   logic fifo_ready;
   logic push;
   logic [N-1:0] par_word;
   logic [1:0] sel;
   usr4_pkg::usr4_mode_t mode;

   assign par_word = {par_in3_in, par_in2_in, par_in1_in, par_in0_in};
   assign sel = {mode_sel_hi_in, mode_sel_lo_in};
   assign mode = usr4_decode(sel);
   // only a rising shift clock edge moves the stages
   assign rise = shift_clk_in && !clk_prev; // RL9 RL11
   assign step = rise && clear_n_in && fifo_ready;
   assign push = step && (mode != usr4_pkg::USR4_HOLD);

   // -----------------------------------------------------------------
   // stage update
   // -----------------------------------------------------------------
   always_comb
   begin
      next_stage = stage; // RL8 RL11
      if (!clear_n_in)
      begin
         next_stage = `USR4_STAGE_RESET; // RL2
      end
      else if (step)
      begin
         unique case (mode)
            usr4_pkg::USR4_LOAD:
            begin
               next_stage = par_word; // RL3
            end
            usr4_pkg::USR4_SHIFT_RIGHT:
            begin
               next_stage = {stage[N-2:0], serial_in_right_in}; // RL4 RL5 RL10
            end
            usr4_pkg::USR4_SHIFT_LEFT:
            begin
               next_stage = {serial_in_left_in, stage[N-1:1]}; // RL6 RL7 RL10
            end
            usr4_pkg::USR4_HOLD:
            begin
               next_stage = stage; // RL8
            end
         endcase
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         stage <= `USR4_STAGE_RESET;
      end
      else
      begin
         stage <= next_stage; // RL1
      end
   end

   // -----------------------------------------------------------------
   // shift clock edge history
   // -----------------------------------------------------------------
   always_comb
   begin
      next_clk_prev = shift_clk_in; // RL9
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         clk_prev <= `USR4_EDGE_RESET;
      end
      else
      begin
         clk_prev <= next_clk_prev;
      end
   end

   // -----------------------------------------------------------------
   // refused edge pulse
   // -----------------------------------------------------------------
   always_comb
   begin
      next_dropped = rise && clear_n_in && !fifo_ready;
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         dropped <= 1'b0;
      end
      else
      begin
         dropped <= next_dropped;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   // clear forces outputs low without waiting for an edge
   assign out0_out = stage[0] && clear_n_in; // RL2
   assign out1_out = stage[1] && clear_n_in;
   assign out2_out = stage[2] && clear_n_in;
   assign out3_out = stage[3] && clear_n_in;
   assign edge_dropped_out = dropped;

   // -----------------------------------------------------------------
   // word stream
   // -----------------------------------------------------------------
   usr4_fifo #(
      .WIDTH(N),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .in_valid_in(push),
      .in_ready_out(fifo_ready),
      .in_data_in(next_stage),
      .out_valid_out(word_valid_out),
      .out_ready_in(word_ready_in),
      .out_data_out(word_data_out)
   );
endmodule : usr4_shift_reg

`default_nettype wire
